// >>> hold_driver.sv
// Model of the external controller driving the hold control pin
`timescale 1ns/10ps
module hold_driver (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst,
  // Command from the bench
  input  wire logic want_hold,
  // Pin, low active
  output logic      pin_n
);
  // Pin rests high so reset never reads as a hold request
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pin_n <= 1'h1;
    end else begin
      pin_n <= ~want_hold;
    end
  end
endmodule

// >>> hold_pkg.sv
// Package of constants for the static power hold controller
package hold_pkg;
  localparam int unsigned CLOCK_MHZ      = 125;
  localparam int unsigned ENTRY_DELAY_NS = 1000;
  localparam int unsigned ENTRY_CYCLES   = (ENTRY_DELAY_NS * CLOCK_MHZ + 999) / 1000;
  localparam int unsigned FILTER_CYCLES  = 8;
  localparam int unsigned SYNC_STAGES    = 2;
  typedef enum logic [1:0] {
    st_run,
    st_arm,
    st_hold
  } hold_state_t;
endpackage

// >>> pin_filter.sv
// Synchroniser and glitch filter for the hold control pin
`timescale 1ns/10ps
module pin_filter
  import hold_pkg::*;
#(
  parameter int unsigned STAGES = SYNC_STAGES,
  parameter int unsigned FILT   = FILTER_CYCLES
) (
  // Clock and reset
  input  wire logic   clock,
  input  wire logic   rst,
  // Raw pin
  input  wire logic   pin_in,
  // Filtered result
  pin_filter_if.filter pf
);
  initial begin
    if (STAGES < 2 || FILT < 2) begin
      $error("pin_filter parameters out of range");
    end
  end

  localparam int unsigned CW = $clog2(FILT + 1);
  localparam logic [CW-1:0] FILT_MAX = CW'(FILT - 1);

  logic [STAGES-1:0] sync;
  logic [CW-1:0]     count;
  logic              level;
  wire               sample = sync[STAGES-1];
  wire               differ = sample != level;
  wire               done   = count == FILT_MAX;

  // Pin idles high; reset to inactive level
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sync <= '1;
    end else begin
      sync <= {sync[STAGES-2:0], pin_in};
    end
  end

  // A level must hold FILT cycles before it is accepted
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      count <= '0;
      level <= 1'b1;
    end else if (!differ) begin
      count <= '0;
    end else if (done) begin
      count <= '0;
      level <= sample;
    end else begin
      count <= count + 1'b1;
    end
  end

  assign pf.sync_level = sample;
  assign pf.filt_level = level;
endmodule

// >>> pin_filter_if.sv
// Interface between the hold controller and its pin filter
`timescale 1ns/10ps
interface pin_filter_if;
  logic sync_level;
  logic filt_level;
  modport filter (output sync_level, output filt_level);
  modport user   (input sync_level, input filt_level);
endinterface

// >>> static_power_hold_ctrl.sv
// Static power hold mode controller
// How it works
// - Hold mode begins one microsecond after the filtered pin goes low.
// - Pin returning high ends hold mode and resumes normal work.
// - Type 1: pin level alone decides entry and exit.
// - Type 2: pin and core condition must agree before any change.
// - Pin glitches shorter than the filter span are ignored.
// - Hold only raises hold_active; no state is cleared while holding.
// - Synchronised pin level goes out to core logic.
// - With hold disabled the pin acts as plain input and output.
`timescale 1ns/10ps
module static_power_hold_ctrl
  import hold_pkg::*;
#(
  parameter int unsigned DELAY  = ENTRY_CYCLES,
  parameter int unsigned FILT   = FILTER_CYCLES,
  parameter int unsigned STAGES = SYNC_STAGES
) (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst,
  // Configuration straps
  input  wire logic hold_enable,
  input  wire logic type2_mode,
  // Hold control pin, low active, usable as ordinary I/O
  input  wire logic hold_ctrl_pin_in_n,
  output logic      hold_ctrl_pin_out,
  output logic      hold_ctrl_pin_oe,
  // Core side
  input  wire logic core_enter_ok,
  input  wire logic core_exit_ok,
  input  wire logic gpio_out,
  input  wire logic gpio_oe,
  output logic      gpio_in,
  output logic      pin_level_core,
  // Status
  output logic      hold_active
);
  initial begin
    if (DELAY < 1 || DELAY > 4096) begin
      $error("static_power_hold_ctrl DELAY out of range");
    end
  end

  localparam int unsigned DW = $clog2(DELAY + 1);
  localparam logic [DW-1:0] DELAY_LAST = DW'(DELAY - 1);

  pin_filter_if pf ();

  pin_filter #(
    .STAGES (STAGES),
    .FILT   (FILT)
  ) u_filter (
    .clock  (clock),
    .rst    (rst),
    .pin_in (hold_ctrl_pin_in_n),
    .pf     (pf)
  );

  hold_state_t     state;
  hold_state_t     next_state;
  logic [DW-1:0]   delay_cnt;
  logic            pin_sync;
  logic            gpio_level;

  // Pin asserted means filtered level low while feature enabled
  wire pin_req   = hold_enable && !pf.filt_level;
  wire enter_ok  = pin_req && (!type2_mode || core_enter_ok);
  wire exit_ok   = !pin_req && (!type2_mode || core_exit_ok);
  wire delay_end = delay_cnt == DELAY_LAST;

  always_comb begin
    next_state = state;
    case (state)
      st_run: begin
        if (enter_ok) begin
          next_state = st_arm;
        end
      end
      st_arm: begin
        // Abort entry if the request drops while counting
        if (!enter_ok) begin
          next_state = st_run;
        end else if (delay_end) begin
          next_state = st_hold;
        end
      end
      st_hold: begin
        if (exit_ok) begin
          next_state = st_run;
        end
      end
      default: next_state = st_run;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= st_run;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      delay_cnt <= '0;
    end else if (state == st_arm && !delay_end) begin
      delay_cnt <= delay_cnt + 1'b1;
    end else if (state != st_arm) begin
      delay_cnt <= '0;
    end
  end

  // Data outputs registered; hold only flags, never clears state
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pin_sync   <= 1'b1;
      gpio_level <= 1'b1;
    end else begin
      pin_sync   <= pf.sync_level;
      gpio_level <= pf.sync_level;
    end
  end

  assign hold_active       = state == st_hold;
  assign pin_level_core    = pin_sync;
  assign gpio_in           = gpio_level;
  // Drive the pin only when the hold feature does not own it
  assign hold_ctrl_pin_out = !hold_enable && gpio_out;
  assign hold_ctrl_pin_oe  = !hold_enable && gpio_oe;

  sequence s_arm_full;
    state == st_arm && delay_end && enter_ok;
  endsequence

  property p_enter_after_delay;
    @(posedge clock) disable iff (rst)
      s_arm_full |=> state == st_hold;
  endproperty
  a_enter_after_delay: assert property (p_enter_after_delay)
    else $error("hold not entered after delay");

  property p_no_early_hold;
    @(posedge clock) disable iff (rst)
      $rose(hold_active) |-> $past(state) == st_arm && $past(delay_end);
  endproperty
  a_no_early_hold: assert property (p_no_early_hold)
    else $error("hold entered before delay");

  property p_exit;
    @(posedge clock) disable iff (rst)
      hold_active && exit_ok |=> !hold_active;
  endproperty
  a_exit: assert property (p_exit)
    else $error("hold not left on exit");

  property p_type1_stays;
    @(posedge clock) disable iff (rst)
      hold_active && !type2_mode && pin_req |=> hold_active;
  endproperty
  a_type1_stays: assert property (p_type1_stays)
    else $error("type 1 hold left while pin low");

  property p_type2_needs_core;
    @(posedge clock) disable iff (rst)
      hold_active && type2_mode && !core_exit_ok |=> hold_active;
  endproperty
  a_type2_needs_core: assert property (p_type2_needs_core)
    else $error("type 2 hold left without core consent");

  property p_disabled_no_hold;
    @(posedge clock) disable iff (rst)
      !hold_enable [*2] |-> !$rose(hold_active);
  endproperty
  a_disabled_no_hold: assert property (p_disabled_no_hold)
    else $error("hold entered while feature disabled");

  property p_core_level;
    @(posedge clock) disable iff (rst)
      pin_level_core == $past(pf.sync_level);
  endproperty
  a_core_level: assert property (p_core_level)
    else $error("core pin level stale");

  property p_hold_flag;
    @(posedge clock) disable iff (rst)
      hold_active && !exit_ok |=> hold_active;
  endproperty
  a_hold_flag: assert property (p_hold_flag)
    else $error("hold flag inconsistent");
endmodule

// >>> tb.sv
// Self-checking bench for the static power hold controller
`timescale 1ns/10ps
module tb;
  import hold_pkg::*;
  `define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin fails++; \
    $display("wrong value at %0t: got %b want %b", $time, a, b); end end
  logic clock = 1'h0, rst = 1'h1, hold_enable = 1'h1, type2_mode = 1'h0;
  logic want_hold = 1'h0, pin_n, pin_out, pin_oe, gpio_in, pin_level_core;
  logic core_enter_ok = 1'h0, core_exit_ok = 1'h0, hold_active;
  logic gpio_out = 1'h0, gpio_oe = 1'h0;
  int   fails = 0, checks_done = 0, cycles = 0;

  always #4 clock = ~clock;

  hold_driver PEER (.clock(clock), .rst(rst), .want_hold(want_hold),
    .pin_n(pin_n));

  // Short entry delay keeps the run brief
  static_power_hold_ctrl #(.DELAY(4)) DUT (.clock(clock), .rst(rst),
    .hold_enable(hold_enable), .type2_mode(type2_mode),
    .hold_ctrl_pin_in_n(pin_n), .hold_ctrl_pin_out(pin_out),
    .hold_ctrl_pin_oe(pin_oe), .core_enter_ok(core_enter_ok),
    .core_exit_ok(core_exit_ok), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
    .gpio_in(gpio_in), .pin_level_core(pin_level_core),
    .hold_active(hold_active));

  task automatic close_out;
    if (fails == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cycles++;
    if (cycles == 2000) begin
      fails++;
      close_out();
    end
  end

  task automatic idle(input int n);
    repeat (n) @(negedge clock);
  endtask

  task automatic pin(input logic v);
    @(posedge clock);
    want_hold <= v;
  endtask

  // Sample off the edge so registered outputs have settled
  task automatic wait_hold(input logic want, input int lim);
    int n;
    n = 0;
    while (hold_active !== want && n < lim) begin
      @(negedge clock);
      n++;
    end
  endtask

  task automatic t_type1;
    pin(1'h1);
    idle(10);
    `CHK(hold_active, 1'h0)
    `CHK(pin_level_core, 1'h0)
    `CHK(gpio_in, 1'h0)
    wait_hold(1'h1, 30);
    `CHK(hold_active, 1'h1)
    idle(20);
    `CHK(hold_active, 1'h1)
    pin(1'h0);
    wait_hold(1'h0, 30);
    `CHK(hold_active, 1'h0)
  endtask

  task automatic t_glitch;
    pin(1'h1);
    pin(1'h1);
    pin(1'h1);
    pin(1'h0);
    idle(40);
    `CHK(hold_active, 1'h0)
  endtask

  task automatic t_type2;
    @(posedge clock);
    type2_mode <= 1'h1;
    pin(1'h1);
    idle(40);
    `CHK(hold_active, 1'h0)
    @(posedge clock);
    core_enter_ok <= 1'h1;
    wait_hold(1'h1, 30);
    `CHK(hold_active, 1'h1)
    pin(1'h0);
    idle(40);
    `CHK(hold_active, 1'h1)
    @(posedge clock);
    core_exit_ok <= 1'h1;
    wait_hold(1'h0, 30);
    `CHK(hold_active, 1'h0)
    @(posedge clock);
    type2_mode <= 1'h0;
    core_enter_ok <= 1'h0;
    core_exit_ok <= 1'h0;
  endtask

  task automatic t_gpio;
    @(posedge clock);
    hold_enable <= 1'h0;
    gpio_out <= 1'h1;
    gpio_oe <= 1'h1;
    pin(1'h1);
    idle(40);
    `CHK(hold_active, 1'h0)
    `CHK(pin_out, 1'h1)
    `CHK(pin_oe, 1'h1)
    `CHK(gpio_in, 1'h0)
    pin(1'h0);
    idle(10);
    @(posedge clock);
    hold_enable <= 1'h1;
    idle(2);
    `CHK(pin_oe, 1'h0)
  endtask

  initial begin
    repeat (3) @(posedge clock);
    rst <= 1'h0;
    t_type1();
    t_glitch();
    t_type2();
    t_gpio();
    close_out();
  end
endmodule
